// ### design/lsp_ports.v
// Top of the two shared LCD I/O ports with APB register access
`timescale 1ns/100ps
`default_nettype none
`include "lsp_defines.vh"
module lsp_ports #(
  parameter WIDTH = `LSP_PORT_W
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Port A pads
  input wire [WIDTH-1:0] port_a_pin_i,
  output wire [WIDTH-1:0] port_a_pin_o,
  output wire [WIDTH-1:0] port_a_pin_oe,
  // Port A alternates: peripheral outputs idle high, inputs see pin level
  input wire [WIDTH-1:0] port_a_periph_out,
  input wire [WIDTH-1:0] port_a_lcd_seg,
  output reg [WIDTH-1:0] port_a_periph_in,
  // Port B pads
  input wire [WIDTH-1:0] port_b_pin_i,
  output wire [WIDTH-1:0] port_b_pin_o,
  output wire [WIDTH-1:0] port_b_pin_oe,
  // Port B segments
  input wire [WIDTH-1:0] port_b_lcd_seg
);
  wire wr_a_latch;
  wire wr_a_drive;
  wire wr_a_lcd;
  wire wr_b_latch;
  wire wr_b_drive;
  wire wr_b_lcd;
  wire hit;
  wire [WIDTH-1:0] port_a_out_latch;
  wire [WIDTH-1:0] port_a_drive_type_sel;
  wire [WIDTH-1:0] port_a_lcd_seg_sel;
  wire [WIDTH-1:0] port_b_out_latch;
  wire [WIDTH-1:0] port_b_drive_type_sel;
  wire [WIDTH-1:0] port_b_lcd_seg_sel;
  reg [WIDTH-1:0] port_a_pin_input;
  reg [WIDTH-1:0] port_b_pin_input;
  reg [31:0] next_prdata;
  localparam [31:0] ZERO = 32'h00000000;

  // Word index of a byte offset, same width as the decoded address bits
  function [9:0] word_idx;
    input [11:0] off;
    begin
      word_idx = off[11:2];
    end
  endfunction

  lsp_apb_slave u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pready(pready),
    .pslverr(pslverr),
    .wr_a_latch(wr_a_latch),
    .wr_a_drive(wr_a_drive),
    .wr_a_lcd(wr_a_lcd),
    .wr_b_latch(wr_b_latch),
    .wr_b_drive(wr_b_drive),
    .wr_b_lcd(wr_b_lcd),
    .hit(hit)
  );

  // Port A: full alternate set, peripheral output gated by latch
  lsp_port_ctrl #(.WIDTH(WIDTH)) u_port_a (
    .pclk(pclk),
    .presetn(presetn),
    .wr_latch(wr_a_latch),
    .wr_drive(wr_a_drive),
    .wr_lcd(wr_a_lcd),
    .wdata(pwdata[WIDTH-1:0]),
    .periph_out(port_a_periph_out),
    .lcd_seg(port_a_lcd_seg),
    .out_latch(port_a_out_latch),
    .drive_type_sel(port_a_drive_type_sel),
    .lcd_seg_sel(port_a_lcd_seg_sel),
    .pin_o(port_a_pin_o),
    .pin_oe(port_a_pin_oe)
  );

  // Port B: no peripheral, so the latch drives alone
  lsp_port_ctrl #(.WIDTH(WIDTH)) u_port_b (
    .pclk(pclk),
    .presetn(presetn),
    .wr_latch(wr_b_latch),
    .wr_drive(wr_b_drive),
    .wr_lcd(wr_b_lcd),
    .wdata(pwdata[WIDTH-1:0]),
    .periph_out({WIDTH{1'b1}}),
    .lcd_seg(port_b_lcd_seg),
    .out_latch(port_b_out_latch),
    .drive_type_sel(port_b_drive_type_sel),
    .lcd_seg_sel(port_b_lcd_seg_sel),
    .pin_o(port_b_pin_o),
    .pin_oe(port_b_pin_oe)
  );

  // Pin levels registered once; reads and peripheral inputs see the same sample
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_pin_input <= {WIDTH{1'b0}};
      port_b_pin_input <= {WIDTH{1'b0}};
      port_a_periph_in <= {WIDTH{1'b0}};
      prdata <= ZERO;
    end else begin
      port_a_pin_input <= port_a_pin_i;
      port_b_pin_input <= port_b_pin_i;
      port_a_periph_in <= port_a_pin_i;
      prdata <= next_prdata;
    end
  end

  // Read data registered in setup; valid during the access cycle
  always @* begin
    next_prdata = ZERO;
    if (psel && !penable && !pwrite && hit) begin
      case (paddr[11:2])
        word_idx(`LSP_OFF_A_LATCH): next_prdata[WIDTH-1:0] = port_a_out_latch;
        word_idx(`LSP_OFF_A_DRIVE): next_prdata[WIDTH-1:0] = port_a_drive_type_sel;
        word_idx(`LSP_OFF_A_LCD): next_prdata[WIDTH-1:0] = port_a_lcd_seg_sel;
        word_idx(`LSP_OFF_A_PIN): next_prdata[WIDTH-1:0] = port_a_pin_input;
        word_idx(`LSP_OFF_A_PERIPH): next_prdata[WIDTH-1:0] = port_a_periph_in;
        word_idx(`LSP_OFF_B_LATCH): next_prdata[WIDTH-1:0] = port_b_out_latch;
        word_idx(`LSP_OFF_B_DRIVE): next_prdata[WIDTH-1:0] = port_b_drive_type_sel;
        word_idx(`LSP_OFF_B_LCD): next_prdata[WIDTH-1:0] = port_b_lcd_seg_sel;
        word_idx(`LSP_OFF_B_PIN): next_prdata[WIDTH-1:0] = port_b_pin_input;
        default: next_prdata = ZERO;
      endcase
    end
  end
endmodule // lsp_ports
`default_nettype wire

// ### design/lsp_defines.vh
// Register offsets, reset values and widths for the shared LCD I/O ports
`ifndef LSP_DEFINES_VH
`define LSP_DEFINES_VH
`define LSP_PORT_W 8
`define LSP_OFF_A_LATCH 12'h000
`define LSP_OFF_A_DRIVE 12'h004
`define LSP_OFF_A_LCD 12'h008
`define LSP_OFF_A_PIN 12'h00c
`define LSP_OFF_A_PERIPH 12'h010
`define LSP_OFF_B_LATCH 12'h020
`define LSP_OFF_B_DRIVE 12'h024
`define LSP_OFF_B_LCD 12'h028
`define LSP_OFF_B_PIN 12'h02c
`define LSP_RST_LATCH 8'hff
`define LSP_RST_DRIVE 8'h00
`define LSP_RST_LCD 8'h00
`endif

// ### design/lsp_port_ctrl.v
// One 8-bit port: control registers and per-pin output stage
`timescale 1ns/100ps
`default_nettype none
`include "lsp_defines.vh"
module lsp_port_ctrl #(
  parameter WIDTH = `LSP_PORT_W
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Register writes
  input wire wr_latch,
  input wire wr_drive,
  input wire wr_lcd,
  input wire [WIDTH-1:0] wdata,
  // Alternate sources
  input wire [WIDTH-1:0] periph_out,
  input wire [WIDTH-1:0] lcd_seg,
  // Register contents
  output reg [WIDTH-1:0] out_latch,
  output reg [WIDTH-1:0] drive_type_sel,
  output reg [WIDTH-1:0] lcd_seg_sel,
  // Pads
  output reg [WIDTH-1:0] pin_o,
  output reg [WIDTH-1:0] pin_oe
);
  integer i;
  reg lvl;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_latch <= `LSP_RST_LATCH;
      drive_type_sel <= `LSP_RST_DRIVE;
      lcd_seg_sel <= `LSP_RST_LCD;
    end else begin
      if (wr_latch) begin
        out_latch <= wdata;
      end
      if (wr_drive) begin
        drive_type_sel <= wdata;
      end
      if (wr_lcd) begin
        lcd_seg_sel <= wdata;
      end
    end
  end

  // Peripheral output is ANDed with the latch, so a latch one lets it through
  always @* begin
    pin_o = {WIDTH{1'b0}};
    pin_oe = {WIDTH{1'b0}};
    lvl = 1'b0;
    for (i = 0; i < WIDTH; i = i + 1) begin
      if (lcd_seg_sel[i]) begin
        pin_o[i] = lcd_seg[i];
        pin_oe[i] = 1'b1;
      end else begin
        lvl = out_latch[i] & periph_out[i];
        pin_o[i] = lvl;
        // Open drain only pulls low; a one floats the pin
        pin_oe[i] = drive_type_sel[i] | ~lvl;
      end
    end
  end
endmodule // lsp_port_ctrl
`default_nettype wire

// ### design/lsp_apb_slave.v
// APB decode for the two port register sets
`timescale 1ns/100ps
`default_nettype none
`include "lsp_defines.vh"
module lsp_apb_slave (
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  output wire pready,
  output wire pslverr,
  // Write strobes
  output wire wr_a_latch,
  output wire wr_a_drive,
  output wire wr_a_lcd,
  output wire wr_b_latch,
  output wire wr_b_drive,
  output wire wr_b_lcd,
  // Address hit
  output wire hit
);
  wire wr;
  function dec;
    input [11:0] a;
    input [11:0] off;
    begin
      dec = (a[11:2] == off[11:2]);
    end
  endfunction
  assign wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign hit = dec(paddr, `LSP_OFF_A_LATCH) | dec(paddr, `LSP_OFF_A_DRIVE) | dec(paddr, `LSP_OFF_A_LCD) |
    dec(paddr, `LSP_OFF_A_PIN) | dec(paddr, `LSP_OFF_A_PERIPH) | dec(paddr, `LSP_OFF_B_LATCH) |
    dec(paddr, `LSP_OFF_B_DRIVE) | dec(paddr, `LSP_OFF_B_LCD) | dec(paddr, `LSP_OFF_B_PIN);
  // Unmapped accesses, reads or writes, and writes to read-only registers answer with an error
  assign pslverr = psel & penable & (~hit | (pwrite & (dec(paddr, `LSP_OFF_A_PIN) |
    dec(paddr, `LSP_OFF_B_PIN) | dec(paddr, `LSP_OFF_A_PERIPH))));
  assign wr_a_latch = wr & dec(paddr, `LSP_OFF_A_LATCH);
  assign wr_a_drive = wr & dec(paddr, `LSP_OFF_A_DRIVE);
  assign wr_a_lcd = wr & dec(paddr, `LSP_OFF_A_LCD);
  assign wr_b_latch = wr & dec(paddr, `LSP_OFF_B_LATCH);
  assign wr_b_drive = wr & dec(paddr, `LSP_OFF_B_DRIVE);
  assign wr_b_lcd = wr & dec(paddr, `LSP_OFF_B_LCD);
endmodule // lsp_apb_slave
`default_nettype wire

// ### sim/lsp_pad_model.sv
// Pad model: pulled-up pins that the far side may sink low
`timescale 1ns/100ps
`default_nettype none
module lsp_pad_model #(
  parameter W = 16
) (
  // Pads
  input wire logic [W-1:0] pin_o,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] ext_low,
  output wire logic [W-1:0] pin_i
);
  // Released pad goes to the pull-up level unless sunk outside
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ~ext_low);
endmodule // lsp_pad_model
`default_nettype wire

// ### sim/lsp_ports_asserts.sv
// Checker for the pad outputs and APB answers of the port pair
`timescale 1ns/100ps
`default_nettype none
module lsp_ports_asserts #(
  parameter WIDTH = 8
) (
  // Clock and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // Pads
  input wire logic [WIDTH-1:0] port_a_pin_i,
  input wire logic [WIDTH-1:0] port_a_pin_o,
  input wire logic [WIDTH-1:0] port_a_pin_oe,
  input wire logic [WIDTH-1:0] port_a_lcd_seg,
  input wire logic [WIDTH-1:0] port_a_periph_in,
  input wire logic [WIDTH-1:0] port_b_pin_o,
  input wire logic [WIDTH-1:0] port_b_pin_oe,
  input wire logic [WIDTH-1:0] port_b_lcd_seg
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr = psel && penable && pwrite;
  wire logic wff = wr && pwdata[7:0] == 8'hff;
  a_rst_float: assert property ($rose(presetn) |-> port_b_pin_oe == '0)
    else $error("port b driven after reset");
  a_lcd_a_seg: assert property (wff && paddr == 12'h008 |=> port_a_pin_o == port_a_lcd_seg && &port_a_pin_oe)
    else $error("port a segment missing");
  a_lcd_b_seg: assert property (wff && paddr == 12'h028 |=> port_b_pin_o == port_b_lcd_seg && &port_b_pin_oe)
    else $error("port b segment missing");
  a_push_pull_a: assert property (wff && paddr == 12'h004 |=> &port_a_pin_oe)
    else $error("port a not push-pull");
  a_push_pull_b: assert property (wff && paddr == 12'h024 |=> &port_b_pin_oe)
    else $error("port b not push-pull");
  a_latch_low: assert property (wr && pwdata[7:0] == 8'h00 && paddr == 12'h000 |=> &port_a_pin_oe)
    else $error("port a low not driven");
  a_periph_copy: assert property ($past(presetn) |-> port_a_periph_in == $past(port_a_pin_i))
    else $error("peripheral input lags wrongly");
  a_ro_refused: assert property (psel && penable && (paddr == 12'h0f0 || wr && paddr == 12'h00c) |-> pslverr)
    else $error("bad access not refused");
endmodule // lsp_ports_asserts
bind lsp_ports lsp_ports_asserts #(.WIDTH(WIDTH)) lsp_ports_asserts_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pslverr, .port_a_pin_i, .port_a_pin_o, .port_a_pin_oe, .port_a_lcd_seg, .port_a_periph_in,
  .port_b_pin_o, .port_b_pin_oe, .port_b_lcd_seg);
`default_nettype wire

// ### sim/tb_lcd_shared_io_ports.sv
// Testbench for the two shared LCD I/O ports
`timescale 1ns/100ps
`default_nettype none
module tb_lcd_shared_io_ports;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [7:0] a_per = 8'hff, a_seg = 0, b_seg = 0, a_o, a_oe, b_o, b_oe, a_in;
  logic [15:0] ext_low = 0, pin_i;
  int fail_count = 0, samples_checked = 0;
  always #5 pclk = ~pclk;
  lsp_ports lsp_ports_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .port_a_pin_i(pin_i[7:0]), .port_a_pin_o(a_o), .port_a_pin_oe(a_oe), .port_a_periph_out(a_per),
    .port_a_lcd_seg(a_seg), .port_a_periph_in(a_in), .port_b_pin_i(pin_i[15:8]), .port_b_pin_o(b_o),
    .port_b_pin_oe(b_oe), .port_b_lcd_seg(b_seg));
  lsp_pad_model lsp_pad_model_i (.pin_o({b_o, a_o}), .pin_oe({b_oe, a_oe}), .ext_low, .pin_i);
  task cmp(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmp_err(input logic got, exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t err got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Idle cycles first, so pin samples settle after the previous write
  task x(input logic w, input logic [11:0] a, input logic [31:0] d, exp, input logic e);
    repeat (2) @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!w) cmp(prdata, exp);
    cmp_err(pslverr, e);
    psel <= 0;
    penable <= 0;
  endtask
  task wrap_up;
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    wrap_up;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 2; i++) begin
      x(0, 12'(i * 32), 0, 32'hff, 0);
      x(0, 12'(i * 32 + 4), 0, 0, 0);
      x(0, 12'(i * 32 + 8), 0, 0, 0);
    end
    ext_low <= 16'h330f;
    x(0, 12'h00c, 0, 32'hf0, 0);
    x(0, 12'h02c, 0, 32'hcc, 0);
    x(1, 12'h000, 32'hffffff00, 0, 0);
    x(0, 12'h000, 0, 0, 0);
    x(0, 12'h00c, 0, 0, 0);
    x(1, 12'h004, 32'hff, 0, 0);
    x(0, 12'h004, 0, 32'hff, 0);
    ext_low <= 16'h00ff;
    x(1, 12'h000, 32'ha5, 0, 0);
    x(0, 12'h00c, 0, 32'ha5, 0);
    x(1, 12'h004, 0, 0, 0);
    x(0, 12'h00c, 0, 0, 0);
    a_seg <= 8'h3c;
    x(1, 12'h008, 32'hff, 0, 0);
    x(0, 12'h008, 0, 32'hff, 0);
    x(0, 12'h00c, 0, 32'h3c, 0);
    ext_low <= 0;
    a_per <= 8'h0f;
    x(1, 12'h000, 32'hff, 0, 0);
    x(1, 12'h008, 0, 0, 0);
    x(0, 12'h00c, 0, 32'h0f, 0);
    x(0, 12'h010, 0, 32'h0f, 0);
    b_seg <= 8'hc3;
    x(1, 12'h028, 32'hff, 0, 0);
    x(0, 12'h02c, 0, 32'hc3, 0);
    x(0, 12'h028, 0, 32'hff, 0);
    x(1, 12'h028, 0, 0, 0);
    x(1, 12'h024, 32'hff, 0, 0);
    x(0, 12'h024, 0, 32'hff, 0);
    x(1, 12'h020, 32'h96, 0, 0);
    ext_low <= 16'hff00;
    x(0, 12'h02c, 0, 32'h96, 0);
    x(0, 12'h020, 0, 32'h96, 0);
    x(1, 12'h024, 0, 0, 0);
    x(0, 12'h02c, 0, 0, 0);
    x(1, 12'h00c, 32'h55, 0, 1);
    x(0, 12'h0f0, 0, 0, 1);
    x(0, 12'h000, 0, 32'hff, 0);
    wrap_up;
  end
endmodule // tb_lcd_shared_io_ports
`default_nettype wire
